/* logic/asq_pkg.sv */
// constants and carrier types for the serial converter sequencer
package asq_pkg;

  localparam int unsigned SLOT_EDGES   = 16;  // clocks per conversion slot
  localparam int unsigned HOLD_EDGE    = 4;   // falling edge that ends tracking
  localparam int unsigned MSB_EDGE     = 5;   // falling edge carrying result msb
  localparam int unsigned LSB_EDGE     = 14;  // falling edge carrying result lsb
  localparam int unsigned CTRL_BITS    = 8;   // control word length
  localparam int unsigned CHAN_MSB     = 5;   // channel code field, top bit
  localparam int unsigned CHAN_LSB     = 3;   // channel code field, bottom bit
  localparam int unsigned RESULT_W     = 10;  // result width
  localparam int unsigned CHAN_W       = CHAN_MSB - CHAN_LSB + 1;
  localparam logic [2:0]  CHAN_RESET   = 3'h0;  // first conversion uses input zero
  localparam logic [2:0]  PINS_RESET   = 3'h4;  // chip select idles high

  typedef enum logic [2:0] {
    ST_IDLE    = 3'b000,  // chip select high, powered down
    ST_ARMED   = 3'b001,  // selected, waiting for first clock fall
    ST_TRACK   = 3'b010,
    ST_CONVERT = 3'b011,
    ST_SLEEP   = 3'b100   // between slots of a continuous frame
  } asq_state_t;

  typedef struct packed {
    logic cs_n;
    logic sclk;
    logic din;
  } asq_pins_t;

  typedef struct packed {
    logic [CHAN_W-1:0] chan_sel;     // analog_input_n selected for tracking
    logic              tracking;
    logic              converting;
    logic              powered;
    logic              hold_strobe;  // one cycle at start of hold
  } asq_analog_t;

endpackage

/* logic/asq_sync.sv */
// two-flop synchroniser with edge detection on the settled level
`timescale 1ns/1ps
module asq_sync
  import asq_pkg::*;
#(
  parameter int unsigned       WIDTH     = 3,
  parameter logic [WIDTH-1:0]  RESET_VAL = '0
) (
  input  wire logic             clock,
  input  wire logic             reset,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] level,
  output logic      [WIDTH-1:0] rise,
  output logic      [WIDTH-1:0] fall
);

  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] stable;
    logic [WIDTH-1:0] prev;
  } asq_sync_state_t;

  asq_sync_state_t state_reg;
  asq_sync_state_t state_next;

  always_comb begin
    state_next.meta   = async_in;
    state_next.stable = state_reg.meta;
    state_next.prev   = state_reg.stable;
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      state_reg <= '{RESET_VAL, RESET_VAL, RESET_VAL};
    end else begin
      state_reg <= state_next;
    end
  end

  // edges come from the second and third flops, never the first
  assign level = state_reg.stable;
  assign rise  = state_reg.stable & ~state_reg.prev;
  assign fall  = ~state_reg.stable & state_reg.prev;

endmodule

/* logic/asq_sequencer.sv */
// serial frame sequencer of the eight-channel converter
//
// How it works
// RQ1 - host frames with chip select low, whole multiples of sixteen clocks
// RQ2 - output driven only while chip select is low, else released
// RQ3 - serial clock edges ignored while chip select is high
// RQ4 - track three clocks, then hold and convert thirteen clocks per slot
// RQ5 - falls 1-4 zeros, 5-14 result msb first, 15-16 zeros
// RQ6 - next slot tracks after sixteenth rise, holds on its fourth fall
// RQ7 - select falling with clock high: track from first clock fall
// RQ8 - select falling with clock low: track now, counts as first fall
// RQ9 - select and clock falling together: track at once
// RQ10 - control word taken on first eight rises of each slot
// RQ11 - captured channel code applies to the following conversion
// RQ12 - control bits five to three form channel code, bit five msb
// RQ13 - other control bits have no effect
// RQ14 - first conversion after power-up samples input zero
// RQ15 - result is straight unsigned binary, ten bits
// RQ16 - host sends a fresh control word every slot
// RQ17 - powered while selected, asleep between slots of continuous frame
// RQ18 - conversions continue back to back while select stays low
// RQ19 - control word shifted msb first
`timescale 1ns/1ps
module asq_sequencer
  import asq_pkg::*;
(
  input  wire logic                clock,
  input  wire logic                reset,
  input  wire asq_pins_t           pins,
  input  wire logic [RESULT_W-1:0] conv_result,
  output logic                     dout,
  output logic                     dout_oe_n,
  output asq_analog_t              analog
);

  typedef struct packed {
    asq_state_t          st;
    logic [4:0]          fall_cnt;
    logic [3:0]          rise_cnt;
    logic [CTRL_BITS-1:0] ctrl_sh;
    logic [CHAN_W-1:0]   chan;
    logic [RESULT_W-1:0] result;
    logic                dout;
    logic                oe_n;
    logic                hold_pulse;
  } asq_core_t;

  localparam asq_core_t CORE_RESET = '{
    st:         ST_IDLE,
    fall_cnt:   5'h00,
    rise_cnt:   4'h0,
    ctrl_sh:    8'h00,
    chan:       CHAN_RESET,
    result:     10'h000,
    dout:       1'b0,
    oe_n:       1'b1,
    hold_pulse: 1'b0
  };

  asq_pins_t lvl;
  asq_pins_t rise;
  asq_pins_t fall;
  asq_core_t core_reg;
  asq_core_t core_next;
  logic      cs_off;
  logic      cs_fall;
  logic      sclk_fall;
  logic      sclk_rise;
  logic [4:0] edge_n;

  asq_sync #(
    .WIDTH     (3),
    .RESET_VAL (PINS_RESET)
  ) u_sync (
    .clock    (clock),
    .reset    (reset),
    .async_in (pins),
    .level    (lvl),
    .rise     (rise),
    .fall     (fall)
  );

  assign cs_off    = lvl.cs_n;
  assign cs_fall   = fall.cs_n;
  assign sclk_fall = fall.sclk;
  assign sclk_rise = rise.sclk;
  assign edge_n    = core_reg.fall_cnt + 5'h01;

  // bit presented on a given falling edge of the slot
  function automatic logic slot_bit(input logic [4:0] e, input logic [RESULT_W-1:0] res);
    int idx;
    idx = int'(RESULT_W) - 1 - (int'(e) - int'(MSB_EDGE));
    if (e >= 5'(MSB_EDGE) && e <= 5'(LSB_EDGE)) begin
      slot_bit = res[idx];  // see RQ5 see RQ15
    end else begin
      slot_bit = 1'b0;
    end
  endfunction

  always_comb begin
    core_next            = core_reg;
    core_next.hold_pulse = 1'b0;
    if (cs_off) begin
      // clock gated off and output released outside a frame
      core_next.st       = ST_IDLE;  // see RQ3
      core_next.fall_cnt = 5'h00;
      core_next.rise_cnt = 4'h0;
      core_next.oe_n     = 1'b1;  // see RQ2
      core_next.dout     = 1'b0;
    end else if (cs_fall) begin
      core_next.oe_n     = 1'b0;  // see RQ2
      core_next.rise_cnt = 4'h0;
      core_next.ctrl_sh  = 8'h00;
      core_next.dout     = 1'b0;
      // synchronised clock low covers both "already low" and "fell together"
      if (!lvl.sclk) begin
        core_next.st       = ST_TRACK;  // see RQ8 see RQ9
        core_next.fall_cnt = 5'h01;
      end else begin
        core_next.st       = ST_ARMED;  // see RQ7
        core_next.fall_cnt = 5'h00;
      end
    end else begin
      if (sclk_fall) begin
        if (core_reg.st == ST_ARMED || core_reg.st == ST_SLEEP) begin
          core_next.st       = ST_TRACK;  // see RQ6 see RQ7 see RQ18
          core_next.fall_cnt = 5'h01;
          core_next.dout     = 1'b0;
        end else begin
          core_next.fall_cnt = edge_n;
          core_next.dout     = slot_bit(edge_n, core_reg.result);  // see RQ5
          if (edge_n == 5'(HOLD_EDGE)) begin
            // sample taken here; the conversion value is latched at hold
            core_next.st         = ST_CONVERT;  // see RQ4 see RQ6
            core_next.hold_pulse = 1'b1;
            core_next.result     = conv_result;  // see RQ15
          end
          if (edge_n == 5'(SLOT_EDGES)) begin
            core_next.st = ST_SLEEP;  // see RQ17
          end
        end
      end
      if (sclk_rise) begin
        core_next.rise_cnt = core_reg.rise_cnt + 4'h1;  // wraps every slot, see RQ6
        if (core_reg.rise_cnt < 4'(CTRL_BITS)) begin
          core_next.ctrl_sh = {core_reg.ctrl_sh[CTRL_BITS-2:0], lvl.din};  // see RQ10 see RQ19
        end
        if (core_reg.rise_cnt == 4'(CTRL_BITS - 1)) begin
          // this conversion already holds, so the new code steers the next one
          core_next.chan = core_reg.ctrl_sh[CHAN_MSB-1:CHAN_LSB-1];  // see RQ11 RQ12 RQ13
        end
      end
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      core_reg <= CORE_RESET;  // see RQ14
    end else begin
      core_reg <= core_next;
    end
  end

  assign dout               = core_reg.dout;
  assign dout_oe_n          = core_reg.oe_n;
  assign analog.chan_sel    = core_reg.chan;
  assign analog.tracking    = (core_reg.st == ST_TRACK);
  assign analog.converting  = (core_reg.st == ST_CONVERT);
  assign analog.powered     = (core_reg.st != ST_IDLE) && (core_reg.st != ST_SLEEP);
  assign analog.hold_strobe = core_reg.hold_pulse;

  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);

  property p_release;
    cs_off |=> dout_oe_n;
  endproperty
  a_release: assert property (p_release) else $error("output not released"); // see RQ2

  property p_drive;
    cs_fall |=> !dout_oe_n ##1 (!dout_oe_n || cs_off);
  endproperty
  a_drive: assert property (p_drive) else $error("output not driven"); // see RQ2

  property p_gated;
    cs_off && sclk_fall |=> core_reg.fall_cnt == 5'h00 && core_reg.st == ST_IDLE;
  endproperty
  a_gated: assert property (p_gated) else $error("clock seen outside frame"); // see RQ3

  property p_hold_edge;
    core_reg.hold_pulse |-> core_reg.fall_cnt == 5'h04 && analog.converting;
  endproperty
  a_hold_edge: assert property (p_hold_edge) else $error("hold on wrong edge"); // see RQ4

  property p_zeros;
    !dout_oe_n && (core_reg.fall_cnt inside {[5'h01:5'h04], 5'h0f, 5'h10}) |-> !dout;
  endproperty
  a_zeros: assert property (p_zeros) else $error("padding bit not zero"); // see RQ5

  property p_msb;
    !cs_off && !cs_fall && sclk_fall && core_reg.st == ST_CONVERT
      && core_reg.fall_cnt == 5'h04 |=> dout == core_reg.result[9];
  endproperty
  a_msb: assert property (p_msb) else $error("msb not on fifth fall"); // see RQ5

  property p_armed;
    cs_fall && !cs_off && lvl.sclk |=> core_reg.st == ST_ARMED ##0 !analog.tracking;
  endproperty
  a_armed: assert property (p_armed) else $error("tracked before first fall"); // see RQ7

  property p_track_now;
    cs_fall && !cs_off && !lvl.sclk |=> analog.tracking && core_reg.fall_cnt == 5'h01;
  endproperty
  a_track_now: assert property (p_track_now) else $error("not tracking at select"); // see RQ8

  property p_chan;
    !cs_off && !cs_fall && sclk_rise && core_reg.rise_cnt == 4'h7
      |=> core_reg.chan == $past(core_reg.ctrl_sh[4:2]);
  endproperty
  a_chan: assert property (p_chan) else $error("channel code not taken"); // see RQ12

  property p_sleep;
    core_reg.fall_cnt == 5'h10 |-> !analog.powered && !analog.converting;
  endproperty
  a_sleep: assert property (p_sleep) else $error("state wrong at slot end"); // see RQ17

  property p_next_slot;
    core_reg.st == ST_SLEEP && sclk_fall && !cs_off && !cs_fall
      |=> analog.tracking && core_reg.fall_cnt == 5'h01 && analog.powered;
  endproperty
  a_next_slot: assert property (p_next_slot) else $error("next slot not started"); // see RQ18

  property p_slot_done;
    core_reg.st == ST_SLEEP && !cs_off;
  endproperty
  c_slot_done: cover property (p_slot_done);

  property p_back_to_back;
    core_reg.st == ST_SLEEP ##[1:200] core_reg.hold_pulse;
  endproperty
  c_back_to_back: cover property (p_back_to_back);

  property p_armed_start;
    core_reg.st == ST_ARMED ##[1:50] analog.tracking;
  endproperty
  c_armed_start: cover property (p_armed_start);

endmodule

/* testbench/asq_host.sv */
// host serial controller model driving the frame pins
`timescale 1ns/1ps
module asq_host
  import asq_pkg::*;
(
  input  wire logic clock,
  input  wire logic dout,
  input  wire logic trk_probe,
  output asq_pins_t pins
);
  logic skip;

  initial begin
    pins = PINS_RESET;
    skip = 1'b0;
  end

  // eight clocks a phase, well above the three-clock sampling minimum
  task automatic step();
    repeat (8) @(posedge clock);
    #1;
  endtask

  // mode 0: select with clock low, 1: clock high, 2: both fall together
  task automatic open(input int mode);
    pins.sclk = (mode != 0);
    step();
    pins.cs_n = 1'b0;
    if (mode == 2) begin
      pins.sclk = 1'b0;
    end
    // select settles alone first, else this is the simultaneous case again
    if (mode == 1) begin
      step();
    end
    skip = (mode != 1);
  endtask

  // one sixteen-clock slot; din changes at falls so it is stable at each rise
  task automatic slot(input logic [7:0] word, output logic [15:0] bits,
                      output logic [15:0] trk);
    for (int k = 0; k < 16; k++) begin
      if (!skip) begin
        pins.sclk = 1'b0;
      end
      skip = 1'b0;
      // released din toggles so a stale bit is never mistaken for data
      pins.din = (k < 8) ? word[7-k] : ~pins.din;
      step();
      bits[15-k] = dout;
      trk[15-k] = trk_probe;
      pins.sclk = 1'b1;
      step();
    end
  endtask

  task automatic close();
    pins.cs_n = 1'b1;
    step();
  endtask
endmodule

/* testbench/eight_channel_adc_serial_sequencer_tb.sv */
// self-checking bench of the serial converter sequencer
`timescale 1ns/1ps
module eight_channel_adc_serial_sequencer_tb;
  import asq_pkg::*;

  typedef struct {
    int         mode;
    logic [7:0] w0;
    logic [7:0] w1;
    logic [9:0] res;
  } asq_row_t;

  logic                clock;
  logic                reset;
  asq_pins_t           pins;
  logic [RESULT_W-1:0] conv_result;
  logic                dout;
  logic                dout_oe_n;
  asq_analog_t         analog;
  logic [15:0]         bits;
  logic [15:0]         trk;
  int                  fails;
  int                  cmp_count;
  int                  holds;
  // codes 0..7 over eight words, ignored bits set in several
  asq_row_t            rows [4] = '{'{0, 8'hc7, 8'h0f, 10'h3ff}, '{1, 8'h10, 8'hdb, 10'h000},
                                    '{2, 8'h27, 8'he9, 10'h2aa}, '{1, 8'h30, 8'hff, 10'h155}};

  asq_sequencer u_asq_sequencer (
    .clock       (clock),
    .reset       (reset),
    .pins        (pins),
    .conv_result (conv_result),
    .dout        (dout),
    .dout_oe_n   (dout_oe_n),
    .analog      (analog)
  );

  asq_host u_asq_host (
    .clock     (clock),
    .dout      (dout),
    .trk_probe (analog.tracking),
    .pins      (pins)
  );

  initial clock = 1'b0;
  always #5 clock = ~clock;

  // hold pulses last one cycle, so they are counted rather than sampled
  always @(posedge clock) begin
    if (analog.hold_strobe === 1'b1) begin
      holds++;
    end
  end

  task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    cmp_count++;
    if (got !== exp) begin
      fails++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic test_done();
    $display("checks %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic do_reset();
    reset = 1'b1;
    repeat (4) @(posedge clock);
    #1;
    reset = 1'b0;
    repeat (3) @(posedge clock);
    #1;
  endtask

  // runs far longer than all frames together
  initial begin
    repeat (20000) @(posedge clock);
    fails++;
    test_done();
  end

  initial begin
    fails = 0;
    cmp_count = 0;
    holds = 0;
    conv_result = '0;
    do_reset();
    chk("oe_n idle", 16'h1, {15'h0, dout_oe_n});
    chk("chan at power-up", 16'h0, {13'h0, analog.chan_sel});
    $display("test reset done");
    foreach (rows[i]) begin
      conv_result = rows[i].res;
      holds = 0;
      u_asq_host.open(rows[i].mode);
      u_asq_host.slot(rows[i].w0, bits, trk);
      chk("dout slot 0", {4'h0, rows[i].res, 2'h0}, bits);
      chk("track slot 0", 16'he000, trk);
      chk("oe_n framed", 16'h0, {15'h0, dout_oe_n});
      chk("chan slot 0", {13'h0, rows[i].w0[5:3]}, {13'h0, analog.chan_sel});
      chk("powered in gap", 16'h0, {15'h0, analog.powered});
      chk("converting in gap", 16'h0, {15'h0, analog.converting});
      chk("holds slot 0", 16'h1, holds[15:0]);
      u_asq_host.slot(rows[i].w1, bits, trk);
      chk("dout slot 1", {4'h0, rows[i].res, 2'h0}, bits);
      chk("track slot 1", 16'he000, trk);
      chk("chan slot 1", {13'h0, rows[i].w1[5:3]}, {13'h0, analog.chan_sel});
      chk("holds frame", 16'h2, holds[15:0]);
      u_asq_host.close();
      chk("oe_n released", 16'h1, {15'h0, dout_oe_n});
      chk("powered off", 16'h0, {15'h0, analog.powered});
      $display("test %0d done", i);
    end
    // clock edges while deselected must leave everything alone
    for (int k = 0; k < 20; k++) begin
      u_asq_host.pins.sclk = ~u_asq_host.pins.sclk;
      u_asq_host.step();
    end
    chk("chan deselected", 16'h7, {13'h0, analog.chan_sel});
    chk("track deselected", 16'h0, {15'h0, analog.tracking});
    chk("oe_n deselected", 16'h1, {15'h0, dout_oe_n});
    $display("test gated clock done");
    do_reset();
    chk("chan after reset", 16'h0, {13'h0, analog.chan_sel});
    $display("test second reset done");
    test_done();
  end
endmodule
